//--- include/cls_pkg.sv
`default_nettype none
package cls_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [31:0] CLS_ADDR_PERIPH_EN   = 32'h01b3_f000;
   localparam logic [31:0] CLS_ADDR_DEV_STATUS  = 32'h01b3_f004;
   localparam logic [31:0] CLS_ADDR_CFG_LOCK    = 32'h01b3_f018;

   // ==========================================================
   // lock register
   localparam logic [31:0] CLS_UNLOCK_KEY       = 32'h10c0_010c;
   localparam int          CLS_LOCK_BIT         = 0;
   localparam logic        CLS_LOCK_RESET       = 1'b1;

   // ==========================================================
   // peripheral enable register: everything off after reset
   localparam logic [31:0] CLS_PERIPH_EN_RESET  = 32'h0000_0000;

   // ==========================================================
   // device status field positions
   localparam int CLS_ST_EMCLK_LSB   = 0;
   localparam int CLS_ST_BOOT_LSB    = 2;
   localparam int CLS_ST_ENDIAN_BIT  = 4;
   localparam int CLS_ST_CLKMUL_LSB  = 5;
   localparam int CLS_ST_RSVD_BIT    = 7;
   localparam int CLS_ST_PCI_BIT     = 8;
   localparam int CLS_ST_EEPROM_BIT  = 9;
   localparam int CLS_ST_HPW_BIT     = 10;
   localparam int CLS_ST_ETH_BIT     = 11;
   localparam int CLS_ST_WIDTH       = 12;
   // little-endian default, all other fields zero
   localparam logic [11:0] CLS_ST_RESET = 12'h010;

   // ==========================================================
   // strap capture: cycles after reset release before sampling
   localparam logic [1:0] CLS_STRAP_SETTLE_CYC = 2'h3;

   // ==========================================================
   // field encodings
   typedef enum logic [1:0] {
      CLS_MUL_X1   = 2'b00,
      CLS_MUL_X6   = 2'b01,
      CLS_MUL_X12  = 2'b10,
      CLS_MUL_RSVD = 2'b11
   } cls_clk_mul_t;

   typedef enum logic [1:0] {
      CLS_BOOT_NONE = 2'b00,
      CLS_BOOT_HOST = 2'b01,
      CLS_BOOT_RSVD = 2'b10,
      CLS_BOOT_EMEM = 2'b11
   } cls_boot_t;

   typedef enum logic [1:0] {
      CLS_EMCLK_INPUT = 2'b00,
      CLS_EMCLK_DIV4  = 2'b01,
      CLS_EMCLK_DIV6  = 2'b10,
      CLS_EMCLK_RSVD  = 2'b11
   } cls_emclk_t;

endpackage : cls_pkg
`default_nettype wire

//--- logic/cls_strap.sv
`timescale 1ns/1ps
`default_nettype none
module cls_strap
   import cls_pkg::*;
#(
   parameter int              W         = 12,
   parameter logic [W-1:0]    RESET_VAL = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // synchronised strap levels
   input  wire logic [W-1:0] level_in,
   // captured value
   output var  logic [W-1:0] value_r,
   output var  logic         done_r
);

   logic [1:0] settle_r;

   // wait for the synchroniser to fill after release, then sample once
   always_ff @(posedge clk) begin
      if (rst) begin
         settle_r <= 2'h0;
         done_r   <= 1'b0;
         value_r  <= RESET_VAL;
      end else if (!done_r) begin
         if (settle_r == CLS_STRAP_SETTLE_CYC) begin
            value_r <= level_in;
            done_r  <= 1'b1;
         end else begin
            settle_r <= settle_r + 2'h1;
         end
      end
   end

endmodule : cls_strap
`default_nettype wire

//--- logic/cls_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cls_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // data
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : cls_sync
`default_nettype wire

//--- logic/cls_top.sv
// Functional notes
// - writing the exact key to the lock register unlocks the enable register.
// - lock register bit 0 reads lock state, 1 locked, resets to 1.
// - while locked, enable register writes leave its contents unchanged.
// - enable register reads return contents regardless of lock state.
// - any write to the enable register relocks it.
// - read-back of enable register completes only after the write took effect.
// - reserved bits of lock and status registers read zero, ignore writes.
// - status bit 11 shows ethernet enable, default 0.
// - status bit 10 shows host port width, 0 sixteen, 1 thirty-two.
// - status bit 9 shows eeprom autoload of pci configuration.
// - status bit 8 shows pci versus host-port group selection.
// - status bits 6:5 show cpu clock multiplier x1, x6, x12.
// - status bit 4 shows byte order, 1 little-endian default.
// - status bits 3:2 show boot source.
// - status bits 1:0 show external memory clock source.
// - enable register accepts new enable bits only while unlocked.
// - after reset all controlled peripherals are disabled.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cls_top
   import cls_pkg::*;
#(
   parameter int PEN_W = 32
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output var  logic [31:0]      prdata,
   output var  logic             pready,
   output var  logic             pslverr,
   // configuration straps
   input  wire logic             ethernet_enable_status,
   input  wire logic             host_port_width,
   input  wire logic             eeprom_autoload_status,
   input  wire logic             pci_select,
   input  wire logic [1:0]       cpu_clock_multiplier,
   input  wire logic             byte_order_flag,
   input  wire logic [1:0]       boot_source,
   input  wire logic [1:0]       ext_mem_clock_source,
   // peripheral enables and lock view
   output var  logic [PEN_W-1:0] periph_enable,
   output var  logic             lock_state_flag
);

   // ==========================================================
   // strap synchronisation and capture
   logic [CLS_ST_WIDTH-1:0] strap_raw;
   logic [CLS_ST_WIDTH-1:0] strap_sync;
   logic [CLS_ST_WIDTH-1:0] status_r;
   logic                    strap_done_r;

   always_comb begin
      strap_raw                                       = '0;
      strap_raw[CLS_ST_ETH_BIT]                       = ethernet_enable_status;
      strap_raw[CLS_ST_HPW_BIT]                       = host_port_width;
      strap_raw[CLS_ST_EEPROM_BIT]                    = eeprom_autoload_status;
      strap_raw[CLS_ST_PCI_BIT]                       = pci_select;
      strap_raw[CLS_ST_CLKMUL_LSB+1:CLS_ST_CLKMUL_LSB] = cpu_clock_multiplier;
      strap_raw[CLS_ST_ENDIAN_BIT]                    = byte_order_flag;
      strap_raw[CLS_ST_BOOT_LSB+1:CLS_ST_BOOT_LSB]    = boot_source;
      strap_raw[CLS_ST_EMCLK_LSB+1:CLS_ST_EMCLK_LSB]  = ext_mem_clock_source;
      // reserved bit 7 never carries a strap
      strap_raw[CLS_ST_RSVD_BIT]                      = 1'b0;
   end

   cls_sync #(
      .W (CLS_ST_WIDTH)
   ) u_strap_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in (strap_raw),
      .sync_out (strap_sync)
   );

   // captured once after release, frozen until next reset
   cls_strap #(
      .W         (CLS_ST_WIDTH),
      .RESET_VAL (CLS_ST_RESET)
   ) u_strap_cap (
      .clk      (clk),
      .rst      (rst),
      .level_in (strap_sync),
      .value_r  (status_r),
      .done_r   (strap_done_r)
   );

   // ==========================================================
   // apb decode
   logic sel_pen;
   logic sel_stat;
   logic sel_lock;
   logic mapped;
   logic acc_phase;
   logic wr_done;
   logic rd_done;
   logic wr_pen;
   logic wr_lock;

   assign sel_pen   = (paddr == CLS_ADDR_PERIPH_EN);
   assign sel_stat  = (paddr == CLS_ADDR_DEV_STATUS);
   assign sel_lock  = (paddr == CLS_ADDR_CFG_LOCK);
   assign mapped    = sel_pen | sel_stat | sel_lock;
   assign acc_phase = psel & penable;
   // writes are accepted only at the completing edge, enable contents change one edge later
   assign wr_done   = acc_phase & pready & pwrite;
   assign rd_done   = acc_phase & pready & ~pwrite;
   assign wr_pen    = wr_done & sel_pen;
   assign wr_lock   = wr_done & sel_lock;

   // ==========================================================
   // lock state
   logic lock_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         lock_r <= CLS_LOCK_RESET;
      end else if (wr_pen) begin
         lock_r <= 1'b1;
      end else if (wr_lock && pwdata == CLS_UNLOCK_KEY) begin
         lock_r <= 1'b0;
      end
      // any other lock write leaves the state alone
   end

   // ==========================================================
   // enable register with a one-cycle commit stage
   // the commit stage models the posted write; read-back waits for it
   logic             pend_r;
   logic [PEN_W-1:0] pend_data_r;
   logic [PEN_W-1:0] pen_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         pend_r      <= 1'b0;
         pend_data_r <= '0;
      end else begin
         // locked writes are dropped here
         pend_r      <= wr_pen & ~lock_r;
         pend_data_r <= pwdata[PEN_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pen_r <= CLS_PERIPH_EN_RESET[PEN_W-1:0];
      end else if (pend_r) begin
         pen_r <= pend_data_r;
      end
   end

   // ==========================================================
   // read data and ready, one wait state per access except a stalled enable read
   logic [31:0] rdata_nxt;
   logic        ready_nxt;
   logic        stall_rd;

   // a read of the enable register holds off while a commit is pending
   assign stall_rd  = ~pwrite & sel_pen & pend_r;
   assign ready_nxt = acc_phase & ~pready & ~stall_rd;

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (sel_pen) begin
         rdata_nxt[PEN_W-1:0] = pen_r;
      end else if (sel_stat) begin
         rdata_nxt[CLS_ST_WIDTH-1:0] = status_r;
      end else if (sel_lock) begin
         rdata_nxt[CLS_LOCK_BIT] = lock_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= ready_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ready_nxt) begin
         prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
         pslverr <= ~mapped;
      end else begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // ==========================================================
   // outputs from flops
   always_ff @(posedge clk) begin
      if (rst) begin
         periph_enable   <= CLS_PERIPH_EN_RESET[PEN_W-1:0];
         lock_state_flag <= CLS_LOCK_RESET;
      end else begin
         periph_enable   <= pen_r;
         lock_state_flag <= lock_r;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_key_write;
      wr_lock && pwdata == CLS_UNLOCK_KEY;
   endsequence

   sequence s_open_pen_write;
      wr_pen && !lock_r;
   endsequence

   sequence s_capture;
      !strap_done_r ##1 strap_done_r;
   endsequence

   a_reset_locked: assert property (
      disable iff (1'b0) rst |=> (lock_r && pen_r == CLS_PERIPH_EN_RESET[PEN_W-1:0])
   ) else $error("lock or enable wrong after reset");

   a_key_unlock: assert property (
      s_key_write |=> !lock_r
   ) else $error("key write did not unlock");

   a_badkey_hold: assert property (
      wr_lock && pwdata != CLS_UNLOCK_KEY |=> lock_r == $past(lock_r)
   ) else $error("non-key write changed lock state");

   a_relock_write: assert property (
      wr_pen |=> lock_r
   ) else $error("enable write did not relock");

   a_locked_hold: assert property (
      wr_pen && lock_r |=> !pend_r ##1 pen_r == $past(pen_r, 2)
   ) else $error("locked write changed enable register");

   a_unlocked_apply: assert property (
      s_open_pen_write |=> pend_r ##1 pen_r == $past(pwdata[PEN_W-1:0], 2)
   ) else $error("unlocked write not applied in two cycles");

   a_readback_waits: assert property (
      rd_done && sel_pen |-> !pend_r && prdata[PEN_W-1:0] == pen_r
   ) else $error("enable read completed before commit");

   a_lock_readback: assert property (
      rd_done && sel_lock |-> prdata == {31'h0000_0000, lock_r}
   ) else $error("lock register read wrong");

   a_status_rsvd: assert property (
      rd_done && sel_stat |-> prdata[31:CLS_ST_WIDTH] == '0 && !prdata[CLS_ST_RSVD_BIT]
   ) else $error("status reserved bits not zero");

   a_status_frozen: assert property (
      strap_done_r |=> status_r == $past(status_r) && strap_done_r
   ) else $error("status changed after capture");

   a_ready_pulse: assert property (
      pready |=> !pready
   ) else $error("ready held over two cycles");

   a_lock_flag_copy: assert property (
      lock_state_flag == $past(lock_r)
   ) else $error("lock flag output does not follow lock state");

   a_enable_out_copy: assert property (
      periph_enable == $past(pen_r)
   ) else $error("enable output does not follow enable register");

   a_enable_commit_only: assert property (
      !pend_r |=> pen_r == $past(pen_r)
   ) else $error("enable register changed without a commit");

   a_lock_stays_set: assert property (
      lock_r && !wr_lock |=> lock_r
   ) else $error("lock cleared without a lock write");

   a_strap_capture: assert property (
      s_capture |-> status_r == $past(strap_sync)
   ) else $error("status did not capture synchronised straps");

   a_status_rsvd_low: assert property (
      !status_r[CLS_ST_RSVD_BIT]
   ) else $error("reserved status bit set");

   a_unmapped_error: assert property (
      pready |-> pslverr == !mapped
   ) else $error("error response does not match decode");

endmodule : cls_top
`default_nettype wire

//--- verif/cls_apb_master.sv
`timescale 1ns/1ps
`default_nettype none
module cls_apb_master (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // request from the bench
   input  wire logic        go,
   input  wire logic        wr,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   output var  logic        done,
   output var  logic [31:0] rdata,
   output var  logic        err,
   // apb master side
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [31:0] paddr,
   output var  logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      {psel, penable, pwrite, done, err} = 5'h0;
      {paddr, pwdata, rdata} = 96'h0;
   end
   // =========================================
   // one transfer at a time, all changes just after an edge
   always @(posedge clk) begin
      done <= 1'b0;
      if (rst) begin
         psel    <= 1'b0;
         penable <= 1'b0;
      end else if (!psel) begin
         if (go) begin
            psel   <= 1'b1;
            pwrite <= wr;
            paddr  <= addr;
            pwdata <= wdata;
         end
      end else if (!penable) begin
         penable <= 1'b1;
      end else if (pready) begin // request held until pready, read waits for the write
         done    <= 1'b1;
         rdata   <= prdata;
         err     <= pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         // released lines must not keep showing the old value
         paddr   <= ~paddr;
         pwdata  <= ~pwdata;
      end
   end
endmodule : cls_apb_master
`default_nettype wire

//--- verif/test_config_lock_and_device_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_config_lock_and_device_status;
   import cls_pkg::*;
   logic clk, rst, go, wr, done, err, psel, penable, pwrite, pready, pslverr, lock_state_flag;
   logic [31:0] addr, wdata, rdata, paddr, pwdata, prdata, periph_enable, r, seed, st;
   logic eth, hpw, eep, pci, endn;
   logic [1:0] mul, boot, emclk;
   logic [32:0] exp_q[$];
   int mismatches, n_compared, cycles;

   cls_apb_master i_cls_apb_master (.clk(clk), .rst(rst), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
      .done(done), .rdata(rdata), .err(err), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   cls_top i_cls_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ethernet_enable_status(eth), .host_port_width(hpw), .eeprom_autoload_status(eep),
      .pci_select(pci), .cpu_clock_multiplier(mul), .byte_order_flag(endn), .boot_source(boot),
      .ext_mem_clock_source(emclk), .periph_enable(periph_enable), .lock_state_flag(lock_state_flag));

   always #2 clk = ~clk;

   // =========================================
   // checking and reporting
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      n_compared++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected at %0t: got %h, want %h", $time, seen, want);
      end
   endtask : check

   task automatic final_report;
      $display("mismatches %0d, compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report

   function automatic logic [31:0] stat_exp;
      return {20'h0, eth, hpw, eep, pci, 1'b0, mul, endn, boot, emclk};
   endfunction : stat_exp

   // bench notes the expectation, the monitor compares when the answer lands
   task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e,
                      input logic er);
      int k;
      exp_q.push_back({er, e});
      go    <= 1'b1;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      go <= 1'b0;
      for (k = 0; k < 50 && done !== 1'b1; k++) @(negedge clk);
      if (k == 50) mismatches++;
      @(posedge clk);
   endtask : acc

   always @(negedge clk) begin
      if (done === 1'b1 && exp_q.size() > 0) check({err, rdata}, exp_q.pop_front());
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         final_report();
      end
   end

   // =========================================
   // main sequence
   initial begin
      {clk, go, wr, eth, hpw, eep, pci, endn, mul, boot, emclk} = 0;
      {addr, wdata} = 64'h0;
      rst = 1'b1;
      seed = 32'hdf55513d;
      // every code of every two-bit strap field, one reset each
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         r = $random(seed);
         rst <= 1'b1;
         {eth, hpw, eep, pci, endn} <= r[4:0];
         {mul, boot, emclk} <= {3{i[1:0]}};
         @(posedge clk);
         rst <= 1'b0;
         repeat (8) @(posedge clk);
         acc(1'b0, CLS_ADDR_DEV_STATUS, 32'h0, stat_exp(), 1'b0);
      end
      acc(1'b0, CLS_ADDR_CFG_LOCK, 32'h0, 32'h1, 1'b0);
      acc(1'b0, CLS_ADDR_PERIPH_EN, 32'h0, 32'h0, 1'b0);
      check({1'b0, periph_enable}, 33'h0);
      r = $random(seed);
      acc(1'b1, CLS_ADDR_PERIPH_EN, r, 32'h0, 1'b0);
      acc(1'b0, CLS_ADDR_PERIPH_EN, 32'h0, 32'h0, 1'b0);
      acc(1'b1, CLS_ADDR_CFG_LOCK, ~CLS_UNLOCK_KEY, 32'h0, 1'b0);
      acc(1'b0, CLS_ADDR_CFG_LOCK, 32'h0, 32'h1, 1'b0);
      acc(1'b1, CLS_ADDR_CFG_LOCK, CLS_UNLOCK_KEY, 32'h0, 1'b0);
      acc(1'b0, CLS_ADDR_CFG_LOCK, 32'h0, 32'h0, 1'b0);
      check({32'h0, lock_state_flag}, 33'h0);
      // all enables in one write, then read back before use
      acc(1'b1, CLS_ADDR_PERIPH_EN, r, 32'h0, 1'b0);
      acc(1'b0, CLS_ADDR_PERIPH_EN, 32'h0, r, 1'b0);
      check({1'b0, periph_enable}, {1'b0, r});
      // the enable write relocked the bank, so a later write of the inverse is dropped
      repeat (128) @(posedge clk);
      acc(1'b0, CLS_ADDR_CFG_LOCK, 32'h0, 32'h1, 1'b0);
      acc(1'b1, CLS_ADDR_PERIPH_EN, ~r, 32'h0, 1'b0);
      acc(1'b0, CLS_ADDR_PERIPH_EN, 32'h0, r, 1'b0);
      // status holds its captured straps against writes and pin changes
      st = stat_exp();
      {eth, hpw, eep, pci, endn, mul, boot, emclk} <= ~{eth, hpw, eep, pci, endn, mul, boot, emclk};
      acc(1'b1, CLS_ADDR_DEV_STATUS, 32'hffff_ffff, 32'h0, 1'b0);
      repeat (6) @(posedge clk);
      acc(1'b0, CLS_ADDR_DEV_STATUS, 32'h0, st, 1'b0);
      acc(1'b0, 32'h01b3_f008, 32'h0, 32'h0, 1'b1);
      acc(1'b1, 32'h01b3_f00c, r, 32'h0, 1'b1);
      repeat (4) @(posedge clk);
      final_report();
   end
endmodule : test_config_lock_and_device_status
`default_nettype wire
